// ---- hw/adc_result_limit_check.sv ----
// Result accumulation, min/max capture and limit checking for one converter engine
// Behaviour
// - A compared result or average above the upper threshold sets the upper fault and raises the interrupt.
// - A compared result or average below the lower threshold sets the lower fault and raises the interrupt.
// - With lower threshold 0x000 and upper threshold 0xFFF no violation can ever be reported.
// - In single-sample mode each 10-bit result is compared directly with the thresholds.
// - With repeat set, cycles restart until a violation interrupt or engine_enable goes low.
// - The average is the 16-bit sum shifted right 2, 3 or 4 for 16, 32 or 64 samples.
// - In average mode the 12-bit shifted average is compared with both thresholds.
// - Reading the conversion status register clears the summary interrupt flag.
// - Status holds done, error, upper fault, lower fault, two zero bits, pin4 and pin2 levels.
// - The cycle's samples are summed in a 16-bit accumulator read as high and low bytes.
// - Minimum and maximum of each cycle are kept as 10-bit values.
module adc_result_limit_check (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       engine_enable,
    input  wire logic       repeat_mode,
    input  wire logic [1:0] sample_count,
    input  wire logic       cycle_start,
    input  wire logic       sample_valid,
    input  wire logic [9:0] sample_data,
    input  wire logic       cycle_end,
    input  wire logic       conv_error,
    input  wire logic       pin4_level,
    input  wire logic       pin2_level,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            cycle_restart,
    output logic            engine_stop,
    output logic            engine_irq_summary,
    output logic            irq
);
    localparam int SW = limit_check_pkg::SAMPLE_W;
    localparam int TW = limit_check_pkg::THRESHOLD_W;

    logic [TW-1:0]                    upper_threshold;
    logic [TW-1:0]                    lower_threshold;
    logic [limit_check_pkg::SUM_W-1:0] sample_sum;
    logic [SW-1:0]                    peak_value;
    logic [SW-1:0]                    trough_value;
    logic                             first_sample;
    logic                             cycle_done;
    logic                             conversion_error;
    logic                             upper_fault;
    logic                             lower_fault;
    logic                             pin4_level_at_eoc;
    logic                             pin2_level_at_eoc;
    logic [1:0]                       pin_sync;
    logic [7:0]                       status_byte;
    logic [TW-1:0]                    average;
    logic [TW-1:0]                    cmp_high;
    logic [TW-1:0]                    cmp_low;
    logic                             hit_upper;
    logic                             hit_lower;
    logic                             cmp_event;
    limit_check_pkg::cmp_state_t      state;

    level_sync #(.WIDTH(2)) pin_sync_inst (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({pin4_level, pin2_level}),
        .sync_out (pin_sync)
    );

    function automatic logic [2:0] avg_shift(input logic [1:0] code);
        case (code)
            limit_check_pkg::COUNT_16: avg_shift = limit_check_pkg::SHIFT_16;
            limit_check_pkg::COUNT_32: avg_shift = limit_check_pkg::SHIFT_32;
            limit_check_pkg::COUNT_64: avg_shift = limit_check_pkg::SHIFT_64;
            default:                   avg_shift = 3'h0;
        endcase
    endfunction

    // Threshold registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_threshold <= limit_check_pkg::UPPER_THRESHOLD_RESET;
            lower_threshold <= limit_check_pkg::LOWER_THRESHOLD_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                limit_check_pkg::ADDR_HIGH_THRESHOLD_UPPER: upper_threshold[11:8] <= reg_wdata[3:0];
                limit_check_pkg::ADDR_HIGH_THRESHOLD_LOWER: upper_threshold[7:0]  <= reg_wdata;
                limit_check_pkg::ADDR_LOW_THRESHOLD_UPPER:  lower_threshold[11:8] <= reg_wdata[3:0];
                limit_check_pkg::ADDR_LOW_THRESHOLD_LOWER:  lower_threshold[7:0]  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Sum, minimum and maximum of the current cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_sum   <= '0;
            peak_value   <= '0;
            trough_value <= '0;
            first_sample <= 1'b1;
        end else if (cycle_start) begin
            sample_sum   <= '0;
            first_sample <= 1'b1;
        end else if (sample_valid) begin
            sample_sum   <= sample_sum + {6'h00, sample_data};
            first_sample <= 1'b0;
            if (first_sample || sample_data > peak_value) begin
                peak_value <= sample_data;
            end
            if (first_sample || sample_data < trough_value) begin
                trough_value <= sample_data;
            end
        end
    end

    // Compare operands: single result or shifted average
    always_comb begin
        average = TW'(sample_sum >> avg_shift(sample_count));
        if (sample_count == limit_check_pkg::COUNT_SINGLE) begin
            cmp_high  = {2'h0, sample_data};
            cmp_low   = {2'h0, sample_data};
            cmp_event = sample_valid && state == limit_check_pkg::CMP_ARMED;
        end else begin
            cmp_high  = average;
            cmp_low   = average;
            cmp_event = cycle_end && state == limit_check_pkg::CMP_ARMED;
        end
        // Strict compares make 0x000 / 0xFFF limits unreachable
        hit_upper = cmp_event && (cmp_high > upper_threshold);
        hit_lower = cmp_event && (cmp_low < lower_threshold);
    end

    // Engine sequencing: keep restarting while armed and repeating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= limit_check_pkg::CMP_IDLE;
            cycle_restart <= 1'b0;
            engine_stop   <= 1'b0;
        end else begin
            cycle_restart <= 1'b0;
            engine_stop   <= 1'b0;
            case (state)
                limit_check_pkg::CMP_IDLE: begin
                    if (engine_enable) begin
                        state <= limit_check_pkg::CMP_ARMED;
                    end
                end
                limit_check_pkg::CMP_ARMED: begin
                    if (!engine_enable) begin
                        state <= limit_check_pkg::CMP_IDLE;
                    end else if (hit_upper || hit_lower) begin
                        state       <= limit_check_pkg::CMP_TRIPPED;
                        engine_stop <= 1'b1;
                    end else if (cycle_end && repeat_mode) begin
                        cycle_restart <= 1'b1;
                    end
                end
                limit_check_pkg::CMP_TRIPPED: begin
                    if (!engine_enable) begin
                        state <= limit_check_pkg::CMP_IDLE;
                    end
                end
                default: state <= limit_check_pkg::CMP_IDLE;
            endcase
        end
    end

    // Status bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_done        <= 1'b0;
            conversion_error  <= 1'b0;
            upper_fault       <= 1'b0;
            lower_fault       <= 1'b0;
            pin4_level_at_eoc <= 1'b0;
            pin2_level_at_eoc <= 1'b0;
        end else begin
            if (cycle_start) begin
                cycle_done <= 1'b0;
            end else if (cycle_end) begin
                cycle_done        <= 1'b1;
                pin4_level_at_eoc <= pin_sync[1];
                pin2_level_at_eoc <= pin_sync[0];
            end
            if (conv_error) begin
                conversion_error <= 1'b1;
            end else if (cycle_start) begin
                conversion_error <= 1'b0;
            end
            if (hit_upper) begin
                upper_fault <= 1'b1;
            end else if (cycle_start && !engine_stop) begin
                upper_fault <= 1'b0;
            end
            if (hit_lower) begin
                lower_fault <= 1'b1;
            end else if (cycle_start && !engine_stop) begin
                lower_fault <= 1'b0;
            end
        end
    end

    // Summary flag: set wins over the clear-on-read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            engine_irq_summary <= 1'b0;
            irq                <= 1'b0;
        end else begin
            if (hit_upper || hit_lower || cycle_end) begin
                engine_irq_summary <= 1'b1;
                irq                <= 1'b1;
            end else if (reg_rd && reg_addr == limit_check_pkg::ADDR_CONVERSION_STATUS) begin
                engine_irq_summary <= 1'b0;
                irq                <= 1'b0;
            end
        end
    end

    always_comb begin
        status_byte                            = 8'h00;
        status_byte[limit_check_pkg::STAT_DONE]  = cycle_done;
        status_byte[limit_check_pkg::STAT_ERROR] = conversion_error;
        status_byte[limit_check_pkg::STAT_UPPER] = upper_fault;
        status_byte[limit_check_pkg::STAT_LOWER] = lower_fault;
        status_byte[limit_check_pkg::STAT_PIN4]  = pin4_level_at_eoc;
        status_byte[limit_check_pkg::STAT_PIN2]  = pin2_level_at_eoc;
    end

    // Registered read data, loaded on a read strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                limit_check_pkg::ADDR_HIGH_THRESHOLD_UPPER: reg_rdata <= {4'h0, upper_threshold[11:8]};
                limit_check_pkg::ADDR_HIGH_THRESHOLD_LOWER: reg_rdata <= upper_threshold[7:0];
                limit_check_pkg::ADDR_LOW_THRESHOLD_UPPER:  reg_rdata <= {4'h0, lower_threshold[11:8]};
                limit_check_pkg::ADDR_LOW_THRESHOLD_LOWER:  reg_rdata <= lower_threshold[7:0];
                limit_check_pkg::ADDR_SUM_ACCUMULATOR_HIGH: reg_rdata <= sample_sum[15:8];
                limit_check_pkg::ADDR_SUM_ACCUMULATOR_LOW:  reg_rdata <= sample_sum[7:0];
                limit_check_pkg::ADDR_PEAK_VALUE_HIGH:      reg_rdata <= {6'h00, peak_value[9:8]};
                limit_check_pkg::ADDR_PEAK_VALUE_LOW:       reg_rdata <= peak_value[7:0];
                limit_check_pkg::ADDR_TROUGH_VALUE_HIGH:    reg_rdata <= {6'h00, trough_value[9:8]};
                limit_check_pkg::ADDR_TROUGH_VALUE_LOW:     reg_rdata <= trough_value[7:0];
                limit_check_pkg::ADDR_CONVERSION_STATUS:    reg_rdata <= status_byte;
                default:                                    reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// ---- hw/limit_check_pkg.sv ----
// Constants for the converter result and limit-check block
package limit_check_pkg;
    localparam logic [7:0] ADDR_HIGH_THRESHOLD_UPPER = 8'h63;
    localparam logic [7:0] ADDR_HIGH_THRESHOLD_LOWER = 8'h64;
    localparam logic [7:0] ADDR_LOW_THRESHOLD_UPPER  = 8'h65;
    localparam logic [7:0] ADDR_LOW_THRESHOLD_LOWER  = 8'h66;
    localparam logic [7:0] ADDR_SUM_ACCUMULATOR_HIGH = 8'h94;
    localparam logic [7:0] ADDR_SUM_ACCUMULATOR_LOW  = 8'h95;
    localparam logic [7:0] ADDR_PEAK_VALUE_HIGH      = 8'h96;
    localparam logic [7:0] ADDR_PEAK_VALUE_LOW       = 8'h97;
    localparam logic [7:0] ADDR_TROUGH_VALUE_HIGH    = 8'h98;
    localparam logic [7:0] ADDR_TROUGH_VALUE_LOW     = 8'h99;
    localparam logic [7:0] ADDR_CONVERSION_STATUS    = 8'h9A;

    localparam int SAMPLE_W    = 10;
    localparam int THRESHOLD_W = 12;
    localparam int SUM_W       = 16;

    // Reset values leave the limits open so nothing trips
    localparam logic [11:0] UPPER_THRESHOLD_RESET = 12'hFFF;
    localparam logic [11:0] LOWER_THRESHOLD_RESET = 12'h000;

    // Sampling-count codes
    localparam logic [1:0] COUNT_SINGLE = 2'h0;
    localparam logic [1:0] COUNT_16     = 2'h1;
    localparam logic [1:0] COUNT_32     = 2'h2;
    localparam logic [1:0] COUNT_64     = 2'h3;

    localparam logic [2:0] SHIFT_16 = 3'h2;
    localparam logic [2:0] SHIFT_32 = 3'h3;
    localparam logic [2:0] SHIFT_64 = 3'h4;

    // Status register bit positions
    localparam int STAT_DONE   = 7;
    localparam int STAT_ERROR  = 6;
    localparam int STAT_UPPER  = 5;
    localparam int STAT_LOWER  = 4;
    localparam int STAT_PIN4   = 1;
    localparam int STAT_PIN2   = 0;

    typedef enum logic [1:0] {
        CMP_IDLE,
        CMP_ARMED,
        CMP_TRIPPED
    } cmp_state_t;
endpackage

// ---- hw/level_sync.sv ----
// Two-flop synchroniser for a bundle of level inputs
module level_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule

// ---- dv/adc_limit_props.sv ----
// Checker of flag, read-back and engine-control relations of the limit-check block
module adc_limit_props (
    input wire logic       clk, rst_n, engine_enable, repeat_mode, cycle_start,
    input wire logic       sample_valid, cycle_end, conv_error, pin4_level, pin2_level,
    input wire logic       reg_wr, reg_rd, cycle_restart, engine_stop, engine_irq_summary, irq,
    input wire logic [1:0] sample_count,
    input wire logic [9:0] sample_data,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic st_rd;
    assign st_rd = reg_rd && reg_addr == limit_check_pkg::ADDR_CONVERSION_STATUS;
    AST_IRQ_FOLLOWS: assert property (irq == engine_irq_summary)
        else $error("irq differs from summary flag");
    AST_READ_CLEARS: assert property (st_rd && !cycle_end && !sample_valid |=>
        !engine_irq_summary) else $error("status read left summary set");
    AST_END_SETS: assert property (cycle_end |=> engine_irq_summary)
        else $error("cycle end did not set summary");
    AST_STOP_FLAGS: assert property (engine_stop |-> engine_irq_summary && !cycle_restart)
        else $error("stop without summary or with restart");
    AST_STOP_ONCE: assert property (engine_stop |=> !engine_stop)
        else $error("stop held longer than one cycle");
    AST_RESTART_CAUSE: assert property (cycle_restart |->
        $past(cycle_end) && $past(repeat_mode) && $past(engine_enable))
        else $error("restart without a repeating cycle end");
    AST_STATUS_GAP: assert property (st_rd |=> reg_rdata[3:2] == 2'h0)
        else $error("unused status bits not zero");
    AST_TEN_BIT: assert property (reg_rd && (reg_addr == 8'h96 || reg_addr == 8'h98)
        |=> reg_rdata[7:2] == 6'h00) else $error("extreme value wider than ten bits");
    AST_TWELVE_BIT: assert property (reg_rd && (reg_addr == 8'h63 || reg_addr == 8'h65)
        |=> reg_rdata[7:4] == 4'h0) else $error("threshold wider than twelve bits");
    C_STOP: cover property (engine_stop);
    C_RESTART: cover property (cycle_restart);
    C_CLEAR: cover property (st_rd && engine_irq_summary);
endmodule
bind adc_result_limit_check adc_limit_props i_adc_limit_props (.clk, .rst_n, .engine_enable,
    .repeat_mode, .cycle_start, .sample_valid, .cycle_end, .conv_error, .pin4_level,
    .pin2_level, .reg_wr, .reg_rd, .cycle_restart, .engine_stop, .engine_irq_summary, .irq,
    .sample_count, .sample_data, .reg_addr, .reg_wdata, .reg_rdata);

// ---- dv/host_model.sv ----
// Host model: register strobes and engine configuration
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr, reg_rd, engine_enable, repeat_mode, rd_done,
    output logic      [1:0] sample_count,
    output logic      [7:0] reg_addr, reg_wdata, rd_val
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_wr, reg_rd, engine_enable, repeat_mode, rd_done} = 5'h00;
        {sample_count, reg_addr, reg_wdata, rd_val} = 26'h0;
    end
    always @(posedge clk) rd_done <= 1'b0;
    // Released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b0, ~a};
        #1;
        rd_val = reg_rdata;
        rd_done = 1'b1;
    endtask
    task automatic cfg(input logic [1:0] cnt);
        @(posedge clk);
        engine_enable <= 1'b0;
        repeat_mode <= 1'b1;
        sample_count <= cnt;
        @(posedge clk);
        engine_enable <= 1'b1;
    endtask
endmodule

// ---- dv/adc_result_limit_check_tb.sv ----
// Self-checking bench for the result and limit-check block
module adc_result_limit_check_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, cycle_start, sample_valid, cycle_end, conv_error, pin4_level;
    logic       pin2_level, reg_wr, reg_rd, engine_enable, repeat_mode, rd_done;
    logic       cycle_restart, engine_stop, engine_irq_summary, irq;
    logic [1:0] sample_count;
    logic [9:0] sample_data;
    logic [9:0] smp [64];
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic [7:0] exp_q [$];
    int         err_total, n_tests;
    int         n_stops = 0, n_restarts = 0;
    logic [7:0] rst_addr [7] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h70, 8'h94, 8'h9A};
    adc_result_limit_check i_adc_result_limit_check (.clk, .rst_n, .engine_enable,
        .repeat_mode, .sample_count, .cycle_start, .sample_valid, .sample_data, .cycle_end,
        .conv_error, .pin4_level, .pin2_level, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .cycle_restart, .engine_stop, .engine_irq_summary, .irq);
    host_model i_host_model (.clk, .reg_rdata, .reg_wr, .reg_rd, .engine_enable, .repeat_mode,
        .rd_done, .sample_count, .reg_addr, .reg_wdata, .rd_val);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        n_tests++;
        if (seen !== expv) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Oldest note is matched against each completed read
    always @(posedge clk) begin
        if (engine_stop === 1'b1) n_stops++;
        if (cycle_restart === 1'b1) n_restarts++;
        if (rd_done === 1'b1) begin
            if (exp_q.size() == 0) err_total++;
            else check(rd_val, exp_q.pop_front());
        end
    end
    task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host_model.rd(a);
    endtask
    task automatic thr(input logic [11:0] up, input logic [11:0] lo);
        i_host_model.wr(8'h63, {4'h0, up[11:8]});
        i_host_model.wr(8'h64, up[7:0]);
        i_host_model.wr(8'h65, {4'h0, lo[11:8]});
        i_host_model.wr(8'h66, lo[7:0]);
    endtask
    // Mode m: 0 boundary values that must not trip, 1 upper trip, 2 lower trip
    task automatic run(input int k, input int m);
        int n;
        logic [15:0] sum;
        logic [11:0] hi, lo;
        logic [9:0] mx, mn;
        logic p4, p2, e;
        int s0, r0;
        s0 = n_stops;
        r0 = n_restarts;
        n = k == 0 ? 4 : 8 << k;
        {sum, mx, mn} = {16'h0000, 10'h000, 10'h3FF};
        for (int i = 0; i < n; i++) begin
            smp[i] = 10'($urandom);
            sum += 16'(smp[i]);
            if (smp[i] > mx) mx = smp[i];
            if (smp[i] < mn) mn = smp[i];
        end
        hi = k == 0 ? 12'(mx) : 12'(sum >> (k + 1));
        lo = k == 0 ? 12'(mn) : hi;
        thr(m == 1 ? hi - 12'h001 : hi, m == 2 ? lo + 12'h001 : lo);
        i_host_model.cfg(2'(k));
        {p4, p2, e} = {1'($urandom), 1'($urandom), 1'(m == 0 && k == 3)};
        @(posedge clk);
        {cycle_start, pin4_level, pin2_level} <= {1'b1, p4, p2};
        @(posedge clk);
        {cycle_start, conv_error} <= {1'b0, e};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            {sample_valid, sample_data, conv_error} <= {1'b1, smp[i], 1'b0};
        end
        @(posedge clk);
        {sample_valid, sample_data} <= {1'b0, ~sample_data};
        @(posedge clk);
        cycle_end <= 1'b1;
        @(posedge clk);
        cycle_end <= 1'b0;
        @(negedge clk);
        check({7'h00, irq}, 8'h01);
        if (m == 0) begin
            expect_rd(8'h94, sum[15:8]);
            expect_rd(8'h95, sum[7:0]);
            expect_rd(8'h96, {6'h00, mx[9:8]});
            expect_rd(8'h97, mx[7:0]);
            expect_rd(8'h98, {6'h00, mn[9:8]});
            expect_rd(8'h99, mn[7:0]);
        end
        expect_rd(8'h9A, {1'b1, e, 1'(m == 1), 1'(m == 2), 2'h0, p4, p2});
        check({7'h00, engine_irq_summary}, 8'h00);
        check(8'(n_stops - s0), {7'h00, m != 0});
        check(8'(n_restarts - r0), {7'h00, m == 0});
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        give_verdict;
    end
    initial begin
        {rst_n, cycle_start, sample_valid, cycle_end, conv_error} = 5'h00;
        {pin4_level, pin2_level, sample_data, err_total, n_tests} = 76'h0;
        void'($urandom(32'h6FFD04C4));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        i_host_model.wr(8'h94, 8'hFF);
        foreach (rst_addr[i])
            expect_rd(rst_addr[i], (i == 0) ? 8'h0F : (i == 1) ? 8'hFF : 8'h00);
        i_host_model.wr(8'h63, 8'hFF);
        expect_rd(8'h63, 8'h0F);
        for (int k = 0; k < 4; k++)
            for (int m = 0; m < 3; m++)
                run(k, m);
        for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk);
        if (exp_q.size() > 0) err_total++;
        give_verdict;
    end
endmodule
